/* hdl/mch_defines.vh */
// Constants for the modem-control handshake block
`ifndef MCH_DEFINES_VH
`define MCH_DEFINES_VH

// Serial frame format and transmit FIFO size
`define MCH_DATA_BITS     8
`define MCH_FIFO_DEPTH    32
`define MCH_FIFO_AW       5

// Baud divider: 200 MHz clock, 16 clocks per bit
`define MCH_CLK_HZ        200000000
`define MCH_BAUD          12500000
`define MCH_BIT_CYCLES    (`MCH_CLK_HZ / `MCH_BAUD)
`define MCH_CNT_W         16
// Reload counts, must track the divider above
`define MCH_BIT_CNT       16'h000F
`define MCH_HALF_CNT      16'h0007

// Transmit states
`define MCH_TX_IDLE       3'h0
`define MCH_TX_REQ        3'h1
`define MCH_TX_SEND       3'h2
`define MCH_TX_DROP       3'h3

// Line levels
`define MCH_MARK          1'b1
`define MCH_SPACE         1'b0

`endif

/* hdl/mch_fifo.v */
// Parameterised valid/ready FIFO for transmit characters
`timescale 1ns/1ps
module mch_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   // Clock and reset
   input  wire             sys_clk_in,
   input  wire             nrst_in,
   // Fill side
   input  wire [WIDTH-1:0] wr_data_in,
   input  wire             wr_valid_in,
   output wire             wr_ready_out,
   // Drain side
   output wire [WIDTH-1:0] rd_data_out,
   output wire             rd_valid_out,
   input  wire             rd_ready_in
);

   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW:0]      wr_ptr_r;
   reg [AW:0]      rd_ptr_r;
   reg [AW:0]      wr_ptr_nxt;
   reg [AW:0]      rd_ptr_nxt;
   reg             wr_ready_r;
   wire            empty;
   wire            do_wr;
   wire            do_rd;

   // Status; ready comes from a flop so the top passes it straight out
   assign empty = (wr_ptr_r == rd_ptr_r);
   assign do_wr = wr_valid_in && wr_ready_r;
   assign do_rd = rd_ready_in && !empty;
   assign wr_ready_out = wr_ready_r;
   assign rd_valid_out = !empty;
   assign rd_data_out  = mem_r[rd_ptr_r[AW-1:0]];

   // Next pointer values
   always @* begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      if (do_wr) begin
         wr_ptr_nxt = wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
         rd_ptr_nxt = rd_ptr_r + 1'b1;
      end
   end

   // Storage write
   always @(posedge sys_clk_in) begin
      if (do_wr) begin
         mem_r[wr_ptr_r[AW-1:0]] <= wr_data_in;
      end
   end

   // Pointer update
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         wr_ptr_r   <= {(AW+1){1'b0}};
         rd_ptr_r   <= {(AW+1){1'b0}};
         wr_ready_r <= 1'b1;
      end else begin
         wr_ptr_r   <= wr_ptr_nxt;
         rd_ptr_r   <= rd_ptr_nxt;
         // Full once the pointers differ by exactly the depth
         wr_ready_r <= !((wr_ptr_nxt[AW-1:0] == rd_ptr_nxt[AW-1:0]) &&
                         (wr_ptr_nxt[AW] != rd_ptr_nxt[AW]));
      end
   end

endmodule // mch_fifo

/* hdl/mch_top.v */
// Terminal-side serial port with modem-control handshake
`timescale 1ns/1ps
`include "mch_defines.vh"

// Notes on behaviour
// [RULE1] Transmit data idles at mark whenever no character is sent.
// [RULE2] The modem keeps receive data at mark between characters.
// [RULE3] Request to send is raised before any data is sent.
// [RULE4] The modem answers request to send with clear to send when ready.
// [RULE5] No transmission starts before clear to send is seen.
// [RULE6] The modem raises data set ready only while operational.
// [RULE7] No data is passed while data set ready is low.
// [RULE8] The modem raises carrier detect while it hears remote carrier.
// [RULE9] Receive data is ignored while carrier detect is low.
// [RULE10] Data terminal ready is raised to activate the modem.
// [RULE11] The modem raises ring indicator on an incoming ring.
// [RULE12] After the last character, request to send drops until clear drops.
module mch_top (
   // Clock and reset
   input  wire       sys_clk_in,
   input  wire       nrst_in,
   // User control
   input  wire       term_enable_in,
   // User transmit stream
   input  wire [7:0] tx_data_in,
   input  wire       tx_valid_in,
   output wire       tx_ready_out,
   // User receive stream
   output reg  [7:0] rx_data_out,
   output reg        rx_valid_out,
   output reg        rx_frame_err_out,
   // User status
   output reg        ring_out,
   output reg        modem_ready_out,
   output reg        carrier_out,
   output reg        tx_busy_out,
   // Modem pins
   output reg        txd_out,
   output reg        rts_out,
   output reg        dtr_out,
   input  wire       rxd_in,
   input  wire       cts_in,
   input  wire       dsr_in,
   input  wire       dcd_in,
   input  wire       ri_in
);

   localparam [`MCH_CNT_W-1:0] BIT_CNT  = `MCH_BIT_CNT;
   localparam [`MCH_CNT_W-1:0] HALF_CNT = `MCH_HALF_CNT;

   // Synchroniser stages for modem inputs
   reg [4:0] sync1_r;
   reg [4:0] sync2_r;
   wire      rxd_s = sync2_r[0];
   wire      cts_s = sync2_r[1];
   wire      dsr_s = sync2_r[2];
   wire      dcd_s = sync2_r[3];
   wire      ri_s  = sync2_r[4];

   // Transmit side state
   reg [2:0]            tx_st_r;
   reg [2:0]            tx_st_nxt;
   reg [`MCH_CNT_W-1:0] tx_cnt_r;
   reg [3:0]            tx_bit_r;
   reg [9:0]            tx_sh_r;
   reg                  tx_last_r;

   // Receive side state
   reg                  rx_act_r;
   reg [`MCH_CNT_W-1:0] rx_cnt_r;
   reg [3:0]            rx_bit_r;
   reg [7:0]            rx_sh_r;

   // FIFO drain side
   wire [7:0] fifo_data;
   wire       fifo_valid;
   wire       fifo_pop;

   // Link usable only while terminal enabled and modem operational
   wire link_ok = dtr_out && dsr_s;

   // True when a bit counter has run out
   function cnt_is_zero;
      input [`MCH_CNT_W-1:0] c;
      begin
         cnt_is_zero = (c == {`MCH_CNT_W{1'b0}});
      end
   endfunction

   // Bit boundary tick in transmit shifter
   wire tx_tick = cnt_is_zero(tx_cnt_r);

   // Frame in flight while the link is lost: cut it short
   wire tx_abort = !tx_last_r && !link_ok;

   // Pop a character at a frame boundary while cleared to send
   assign fifo_pop = (tx_st_r == `MCH_TX_SEND) && tx_last_r && tx_tick &&
                     fifo_valid && cts_s && link_ok; // [RULE5] [RULE7]

   // Reaches value for start of count
   function [`MCH_CNT_W-1:0] cnt_dec;
      input [`MCH_CNT_W-1:0] c;
      input [`MCH_CNT_W-1:0] reload;
      begin
         if (cnt_is_zero(c)) begin
            cnt_dec = reload;
         end else begin
            cnt_dec = c - 1'b1;
         end
      end
   endfunction

   // Transmit character buffer
   mch_fifo #(
      .WIDTH (`MCH_DATA_BITS),
      .DEPTH (`MCH_FIFO_DEPTH),
      .AW    (`MCH_FIFO_AW)
   ) u_fifo (
      .sys_clk_in   (sys_clk_in),
      .nrst_in      (nrst_in),
      .wr_data_in   (tx_data_in),
      .wr_valid_in  (tx_valid_in),
      .wr_ready_out (tx_ready_out),
      .rd_data_out  (fifo_data),
      .rd_valid_out (fifo_valid),
      .rd_ready_in  (fifo_pop)
   );

   // Two-stage synchroniser for all modem inputs
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         sync1_r <= 5'h01; // Same idle levels as stage two
         sync2_r <= 5'h01;
      end else begin
         sync1_r <= {ri_in, dcd_in, dsr_in, cts_in, rxd_in};
         sync2_r <= sync1_r;
      end
   end

   // Terminal ready and status outputs
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         dtr_out         <= 1'b0;
         ring_out        <= 1'b0;
         modem_ready_out <= 1'b0;
         carrier_out     <= 1'b0;
      end else begin
         dtr_out         <= term_enable_in; // [RULE10]
         ring_out        <= ri_s; // [RULE11]
         modem_ready_out <= dsr_s; // [RULE6]
         carrier_out     <= dcd_s; // [RULE8]
      end
   end

   // Transmit handshake next state
   always @* begin
      tx_st_nxt = tx_st_r;
      case (tx_st_r)
         `MCH_TX_IDLE: begin
            if (fifo_valid && link_ok && !cts_s) begin
               tx_st_nxt = `MCH_TX_REQ; // [RULE3]
            end
         end
         `MCH_TX_REQ: begin
            if (!link_ok) begin
               tx_st_nxt = `MCH_TX_DROP; // [RULE7]
            end else if (cts_s) begin
               tx_st_nxt = `MCH_TX_SEND; // [RULE4] [RULE5]
            end
         end
         `MCH_TX_SEND: begin
            if (!link_ok) begin
               tx_st_nxt = `MCH_TX_DROP; // [RULE7]
            end else if (tx_last_r && tx_tick && !fifo_pop) begin
               tx_st_nxt = `MCH_TX_DROP; // [RULE12]
            end
         end
         `MCH_TX_DROP: begin
            if (!cts_s) begin
               tx_st_nxt = `MCH_TX_IDLE; // [RULE12]
            end
         end
         default: begin
            tx_st_nxt = `MCH_TX_IDLE;
         end
      endcase
   end

   // Transmit state, request line and shifter
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         tx_st_r     <= `MCH_TX_IDLE;
         rts_out     <= 1'b0;
         txd_out     <= `MCH_MARK;
         tx_cnt_r    <= {`MCH_CNT_W{1'b0}};
         tx_bit_r    <= 4'h0;
         tx_sh_r     <= 10'h3FF;
         tx_last_r   <= 1'b1;
         tx_busy_out <= 1'b0;
      end else begin
         tx_st_r     <= tx_st_nxt;
         rts_out     <= (tx_st_nxt == `MCH_TX_REQ) ||
                        (tx_st_nxt == `MCH_TX_SEND); // [RULE3] [RULE12]
         tx_busy_out <= (tx_st_nxt != `MCH_TX_IDLE);
         if (fifo_pop) begin
            tx_sh_r   <= {`MCH_MARK, fifo_data, `MCH_SPACE};
            tx_bit_r  <= 4'h0;
            tx_cnt_r  <= BIT_CNT;
            tx_last_r <= 1'b0;
            txd_out   <= `MCH_SPACE;
         end else if (tx_abort) begin
            tx_last_r <= 1'b1; // Frame dropped, line back to mark
            tx_cnt_r  <= {`MCH_CNT_W{1'b0}};
            txd_out   <= `MCH_MARK; // [RULE7]
         end else if (!tx_last_r) begin
            tx_cnt_r <= cnt_dec(tx_cnt_r, BIT_CNT);
            if (tx_tick) begin
               if (tx_bit_r == 4'h9) begin
                  tx_last_r <= 1'b1; // Stop bit fully sent
                  txd_out   <= `MCH_MARK; // [RULE1]
               end else begin
                  tx_bit_r <= tx_bit_r + 4'h1;
                  txd_out  <= tx_sh_r[tx_bit_r + 4'h1];
               end
            end
         end else begin
            txd_out  <= `MCH_MARK; // [RULE1]
            tx_cnt_r <= {`MCH_CNT_W{1'b0}};
         end
      end
   end

   // Receiver, gated by carrier and data set ready
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         rx_act_r         <= 1'b0;
         rx_cnt_r         <= {`MCH_CNT_W{1'b0}};
         rx_bit_r         <= 4'h0;
         rx_sh_r          <= 8'h00;
         rx_data_out      <= 8'h00;
         rx_valid_out     <= 1'b0;
         rx_frame_err_out <= 1'b0;
      end else begin
         rx_valid_out     <= 1'b0;
         rx_frame_err_out <= 1'b0;
         if (!dcd_s || !link_ok) begin
            rx_act_r <= 1'b0; // [RULE9] [RULE7]
         end else if (!rx_act_r) begin
            if (rxd_s == `MCH_SPACE) begin
               rx_act_r <= 1'b1; // Start edge after idle mark [RULE2]
               rx_cnt_r <= HALF_CNT;
               rx_bit_r <= 4'h0;
            end
         end else if (!cnt_is_zero(rx_cnt_r)) begin
            rx_cnt_r <= rx_cnt_r - 1'b1;
         end else begin
            rx_cnt_r <= BIT_CNT;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0) begin
               if (rxd_s != `MCH_SPACE) begin
                  rx_act_r <= 1'b0; // False start glitch
               end
            end else if (rx_bit_r == 4'h9) begin
               rx_act_r <= 1'b0;
               if (rxd_s == `MCH_MARK) begin
                  rx_data_out  <= rx_sh_r;
                  rx_valid_out <= 1'b1;
               end else begin
                  rx_frame_err_out <= 1'b1;
               end
            end else begin
               rx_sh_r <= {rxd_s, rx_sh_r[7:1]};
            end
         end
      end
   end

endmodule // mch_top

/* verif/mch_modem_model.sv */
// Modem model on the terminal's serial pins
`timescale 1ns/1ps
`include "mch_defines.vh"
module mch_modem_model #(
   parameter CTS_DLY = 24
) (
   // Clock and pins
   input  wire sys_clk_in,
   input  wire rts_in,
   output reg  cts_out,
   output reg  rxd_out,
   output reg  dsr_out,
   output reg  dcd_out,
   output reg  ri_out
);
   integer cnt;
   // Idle levels; status set by the bench
   initial begin
      cts_out = 1'b0;
      rxd_out = 1'b1;
      dsr_out = 1'b0;
      dcd_out = 1'b0;
      ri_out  = 1'b0;
      cnt     = 0;
   end
   // Clear to send follows request after a delay
   always @(posedge sys_clk_in) begin
      cnt <= ((rts_in && dsr_out) == cts_out) ? 0 : cnt + 1;
      if (cnt == CTS_DLY)
         cts_out <= rts_in && dsr_out;
   end
   // One 8N1 character, mark afterwards
   task send_char(input [7:0] c);
      integer i;
      for (i = 0; i < 10; i = i + 1) begin
         rxd_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i-1];
         repeat (`MCH_BIT_CYCLES) @(posedge sys_clk_in);
      end
   endtask
endmodule // mch_modem_model

/* verif/mch_props.sv */
// Port assertions for the handshake block
`timescale 1ns/1ps
module mch_props (
   // Clock and reset
   input wire sys_clk_in,
   input wire nrst_in,
   // Watched ports
   input wire term_enable_in,
   input wire rx_valid_out,
   input wire tx_busy_out,
   input wire txd_out,
   input wire rts_out,
   input wire dtr_out,
   input wire cts_in,
   input wire dsr_in,
   input wire dcd_in
);
   // One clock domain
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   property p_idle_mark; !tx_busy_out |-> txd_out; endproperty
   a_idle_mark: assert property (p_idle_mark) else $error("txd off mark");
   property p_start_rts; $fell(txd_out) |-> rts_out; endproperty
   a_start_rts: assert property (p_start_rts) else $error("no rts");
   property p_start_cts; $fell(txd_out) |-> $past(cts_in, 3); endproperty
   a_start_cts: assert property (p_start_cts) else $error("no cts");
   property p_start_dsr;
      $fell(txd_out) |-> $past(dsr_in, 3) && dtr_out;
   endproperty
   a_start_dsr: assert property (p_start_dsr) else $error("no dsr");
   property p_rx_carrier; (!dcd_in) [*4] |=> !rx_valid_out; endproperty
   a_rx_carrier: assert property (p_rx_carrier) else $error("rx no dcd");
   property p_dtr;
      $past(nrst_in) |-> dtr_out == $past(term_enable_in);
   endproperty
   a_dtr: assert property (p_dtr) else $error("dtr lag");
   property p_rts_end; $fell(rts_out) |-> txd_out; endproperty
   a_rts_end: assert property (p_rts_end) else $error("rts early");
   property p_rts_rearm; $rose(rts_out) |-> !$past(cts_in, 3); endproperty
   a_rts_rearm: assert property (p_rts_rearm) else $error("rts rearm");
endmodule // mch_props
bind mch_top mch_props i_mch_props (.sys_clk_in, .nrst_in,
   .term_enable_in, .rx_valid_out, .tx_busy_out, .txd_out, .rts_out,
   .dtr_out, .cts_in, .dsr_in, .dcd_in);

/* verif/tb_mch_top.sv */
// Self-checking bench for the handshake block
`timescale 1ns/1ps
`include "mch_defines.vh"
module tb_mch_top;
   reg        sys_clk_in = 1'b0;
   reg        nrst_in = 1'b0;
   reg        term_enable_in = 1'b0;
   reg  [7:0] tx_data_in = 8'h00;
   reg        tx_valid_in = 1'b0;
   wire [7:0] rx_data_out;
   wire       tx_ready_out, rx_valid_out, ring_out, carrier_out;
   wire       rx_frame_err_out, modem_ready_out;
   wire       tx_busy_out, txd_out, rts_out, dtr_out;
   wire       rxd_in, cts_in, dsr_in, dcd_in, ri_in;
   integer    err_total = 0;
   integer    comparisons = 0;
   integer    rx_cnt = 0;
   integer    fe_cnt = 0;
   integer    i;
   reg  [7:0] got;
   // Clock and receive pulse count
   always #2.5 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) if (rx_valid_out === 1'b1) rx_cnt <= rx_cnt + 1;
   always @(posedge sys_clk_in)
      if (rx_frame_err_out === 1'b1) fe_cnt <= fe_cnt + 1;
   mch_top i_mch_top (.sys_clk_in, .nrst_in, .term_enable_in, .tx_data_in,
      .tx_valid_in, .tx_ready_out, .rx_data_out, .rx_valid_out,
      .rx_frame_err_out, .ring_out, .modem_ready_out, .carrier_out,
      .tx_busy_out, .txd_out, .rts_out, .dtr_out, .rxd_in, .cts_in, .dsr_in,
      .dcd_in, .ri_in);
   mch_modem_model i_mch_modem_model (.sys_clk_in, .rts_in(rts_out),
      .cts_out(cts_in), .rxd_out(rxd_in), .dsr_out(dsr_in),
      .dcd_out(dcd_in), .ri_out(ri_in));
   // Compare and count
   task chk(input [7:0] g, input [7:0] e);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   // Bounded wait for rts (0) or txd (1) to reach a level
   task wt(input s, input v, input integer n);
      while ((s ? txd_out : rts_out) !== v && n > 0) begin
         @(posedge sys_clk_in);
         n = n - 1;
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   task give_verdict;
      begin
         $display("Checks %0d mismatches %0d", comparisons, err_total);
         if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // Queued char waits for data set ready, then goes out
   task t_tx;
      begin
         tx_data_in <= 8'hA5;
         tx_valid_in <= 1'b1;
         cyc(1);
         tx_valid_in <= 1'b0;
         cyc(200);
         chk({rts_out, txd_out}, 8'h01);
         i_mch_modem_model.dsr_out <= 1'b1;
         wt(0, 1'b1, 50);
         chk({rts_out, cts_in, txd_out, modem_ready_out}, 8'h0B);
         wt(1, 1'b0, 100);
         cyc(`MCH_BIT_CYCLES / 2);
         for (i = 0; i < 8; i = i + 1) begin
            cyc(`MCH_BIT_CYCLES);
            got[i] = txd_out;
         end
         chk(got, 8'hA5);
         wt(0, 1'b0, 2 * `MCH_BIT_CYCLES);
         chk({rts_out, txd_out}, 8'h01);
         cyc(60);
         chk({rts_out, tx_busy_out, txd_out}, 8'h01);
      end
   endtask
   // Receive ignored without carrier, taken with it
   task t_rx;
      begin
         i_mch_modem_model.send_char(8'h3C);
         chk(rx_cnt, 0);
         i_mch_modem_model.dcd_out <= 1'b1;
         i_mch_modem_model.ri_out <= 1'b1;
         cyc(5);
         chk({carrier_out, ring_out}, 8'h03);
         i_mch_modem_model.send_char(8'hC3);
         chk(rx_cnt, 1);
         chk(rx_data_out, 8'hC3);
         // Ten bit times of space: one framing error, no character
         i_mch_modem_model.rxd_out <= 1'b0;
         cyc(10 * `MCH_BIT_CYCLES);
         i_mch_modem_model.rxd_out <= 1'b1;
         cyc(2 * `MCH_BIT_CYCLES);
         chk(fe_cnt, 1);
         chk(rx_cnt, 1);
      end
   endtask
   // Fill buffer with no modem, expect refusal, then reset
   task t_fill;
      begin
         i_mch_modem_model.dsr_out <= 1'b0;
         cyc(5);
         tx_valid_in <= 1'b1;
         cyc(40);
         chk(tx_ready_out, 8'h00);
         tx_valid_in <= 1'b0;
         chk({rts_out, modem_ready_out}, 8'h00);
         nrst_in <= 1'b0;
         cyc(6);
         chk({tx_ready_out, txd_out, dtr_out}, 8'h06);
      end
   endtask
   // Main sequence
   initial begin
      cyc(6);
      chk({txd_out, rts_out, dtr_out, tx_ready_out}, 8'h09);
      nrst_in <= 1'b1;
      term_enable_in <= 1'b1;
      cyc(3);
      chk(dtr_out, 8'h01);
      t_tx;
      t_rx;
      t_fill;
      give_verdict;
   end
   // Watchdog
   initial begin
      #100000;
      err_total = err_total + 1;
      give_verdict;
   end
endmodule // tb_mch_top
